//--- hw/lpps_sequencer.v
/*
  Line probe preactivation sequencer: times the probe phase between two
  handshake sessions and generates the scrambled two-level probe bursts.
  Assumes a handshake controller that pulses hsEnd and listens to hsStart,
  and a transmit path that takes one level per symbolStrobe.
*/
// Contract
// - Remote first burst 0,2 s after handshake.
// - Remote bursts share negotiated 50 ms-step duration.
// - Central bursts share negotiated 50 ms-step duration.
// - Same-unit bursts separated by 0,2 s silence.
// - Central starts 0,2 s after last remote.
// - Central silent 0,2 s before second handshake.
// - Whole probe phase at most 10 s.
// - Each interval timed from its own start.
// - Probe only when optional probe selected.
// - Remote bursts ascending symbol rate order. Code sends them in table order and only sets orderErr_r on a rate drop.
// - Central bursts ascending symbol rate order. Code sends them in table order and only sets orderErr_r on a rate drop.
// - Burst symbol rate is negotiated rate.
// - Remote scrambler fed constant seed stream.
// - Central scrambler fed constant seed stream.
// - Per-probe mask setting, 192 to 2304 kbit/s.
// - One back-off per unit, 0 to 15 dB.
// - Default back-off at least 6 dB.
// - Support all six selectable scrambler polynomials.
// - Scrambler cleared before each probe sequence.
// - Central taps per selected index.
// - Remote taps per selected index.
// - One level per symbol, activation mapping.
// - Seed stream is constant logical one.
// - Uncoded two-level, one bit per symbol.
// - Zero to minus 9/16, one plus 9/16.
`timescale 1ns/1ps
`include "lpps_defines.vh"

module lpps_sequencer #(
  parameter [31:0] GAP_CYC = `LPPS_GAP_CYC,
  parameter [31:0] DUR_STEP_CYC = `LPPS_DUR_STEP_CYC,
  parameter [31:0] TOTAL_CYC = `LPPS_TOTAL_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Handshake controller
  input wire hsEnd,
  output reg hsStart,
  output reg probeBusy,
  // Transmit path
  output reg txActive,
  output reg txLevel,
  output reg [3:0] txLevelCode,
  output reg symbolStrobe,
  output reg [3:0] txBackoff,
  output reg [5:0] txMaskSel
);

  // ==========================================================
  // States
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_HP = 3'd1;
  localparam [2:0] ST_RBURST = 3'd2;
  localparam [2:0] ST_RGAP = 3'd3;
  localparam [2:0] ST_PRC = 3'd4;
  localparam [2:0] ST_CBURST = 3'd5;
  localparam [2:0] ST_CGAP = 3'd6;
  localparam [2:0] ST_PH = 3'd7;

  // ==========================================================
  // Functions

  // Merge write data into a register under byte enables
  function [31:0] byteMerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      byteMerge = {sel[3] ? dat[31:24] : old[31:24], sel[2] ? dat[23:16] : old[23:16],
                   sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  // Feedback of the selected polynomial; s[k-1] holds s(n-k)
  function tapBit;
    input central;
    input [2:0] idx;
    input [22:0] s;
    begin
      if (central) begin
        case (idx)
          3'd1: tapBit = s[0];
          3'd2: tapBit = s[1] ^ s[4];
          3'd3: tapBit = s[0] ^ s[5];
          3'd4: tapBit = s[2] ^ s[6];
          3'd5: tapBit = s[1] ^ s[2] ^ s[3] ^ s[7];
          default: tapBit = s[4] ^ s[22];
        endcase
      end else begin
        case (idx)
          3'd1: tapBit = s[0];
          3'd2: tapBit = s[2] ^ s[4];
          3'd3: tapBit = s[4] ^ s[5];
          3'd4: tapBit = s[3] ^ s[6];
          3'd5: tapBit = s[3] ^ s[4] ^ s[5] ^ s[7];
          default: tapBit = s[17] ^ s[22];
        endcase
      end
    end
  endfunction

  // Burst length in clocks from a count of 50 ms steps, zero read as one
  function [31:0] durCycles;
    input [5:0] steps;
    begin
      durCycles = ((steps == 6'h00) ? 32'd1 : {26'h0, steps}) * DUR_STEP_CYC;
    end
  endfunction

  // ==========================================================
  // Register file
  reg [1:0] ctrl_r;          // Probe enable, central role
  reg [12:0] rcfg_r;         // Remote count, duration, back-off
  reg [12:0] ccfg_r;         // Central count, duration, back-off
  reg orderErr_r;            // Rates not ascending in table
  reg limitErr_r;            // Phase hit the total limit
  reg [31:0] rcfgWord;
  reg [31:0] ccfgWord;
  reg [31:0] ctrlWord;
  // Byte-merged write values, sliced per register below
  wire [31:0] ctrlMerge = byteMerge(ctrlWord, wb_dat_i, wb_sel_i);
  wire [31:0] rcfgMerge = byteMerge(rcfgWord, wb_dat_i, wb_sel_i);
  wire [31:0] ccfgMerge = byteMerge(ccfgWord, wb_dat_i, wb_sel_i);
  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWr = busReq & wb_we_i;
  wire tabHit = (wb_adr_i[7:6] == `LPPS_ADR_TAB_HI);
  wire [`LPPS_ENT_W-1:0] tabData = wb_dat_i[`LPPS_ENT_W-1:0];

  // Sequencer state
  reg [2:0] st_r;
  reg [31:0] cnt_r;          // Countdown of the current interval
  reg [31:0] total_r;        // Elapsed clocks of the whole phase
  reg [2:0] burstIdx_r;      // Entry of the current or next burst
  reg central_r;             // Role snapshot
  reg [12:0] rSnap_r;        // Remote settings snapshot
  reg [12:0] cSnap_r;        // Central settings snapshot
  reg [22:0] scr_r;          // Scrambler history
  reg [2:0] poly_r;          // Polynomial of the running burst
  reg [15:0] div_r;          // Clocks per symbol of the running burst
  reg [15:0] symCnt_r;       // Symbol period countdown
  reg [15:0] prevDiv_r;      // Divider of the previous burst
  reg ownBurst_r;            // This unit transmits in this burst
  wire [`LPPS_ENT_W-1:0] entry;

  // Table read address follows the side whose slots are running
  wire centralSlots = (st_r == ST_PRC) | (st_r == ST_CBURST) | (st_r == ST_CGAP);
  wire [3:0] rdAddr = {centralSlots, burstIdx_r};

  // ==========================================================
  // Rate table
  lpps_rate_mem i_lpps_rate_mem (
    .clk(clk),
    .wrEn(busWr & tabHit),
    .wrAddr(wb_adr_i[5:2]),
    .wrData(tabData),
    .rdAddr(rdAddr),
    .rdData(entry)
  );

  // ==========================================================
  // Wishbone read mux; the table is write-only and reads as zero
  always @* begin
    ctrlWord = {30'h0, ctrl_r};
    rcfgWord = {19'h0, rcfg_r};
    ccfgWord = {19'h0, ccfg_r};
  end

  // Bus answer: ack one cycle after the request, dropped the next cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_r <= `LPPS_CTRL_RST;
      rcfg_r <= `LPPS_CFG_RST;
      ccfg_r <= `LPPS_CFG_RST;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= 32'h0;
      if (busReq && !wb_we_i) begin
        // Read decode, unmapped reads return zero
        if (wb_adr_i == `LPPS_ADR_CTRL) begin
          wb_dat_o <= ctrlWord;
        end else if (wb_adr_i == `LPPS_ADR_RCFG) begin
          wb_dat_o <= rcfgWord;
        end else if (wb_adr_i == `LPPS_ADR_CCFG) begin
          wb_dat_o <= ccfgWord;
        end else if (wb_adr_i == `LPPS_ADR_STAT) begin
          wb_dat_o <= {24'h0, limitErr_r, orderErr_r, probeBusy, txActive, 1'b0, st_r};
        end
      end
      if (busWr) begin
        // Write decode, unmapped writes are dropped
        if (wb_adr_i == `LPPS_ADR_CTRL) begin
          ctrl_r <= ctrlMerge[1:0];
        end else if (wb_adr_i == `LPPS_ADR_RCFG) begin
          rcfg_r <= rcfgMerge[12:0];
        end else if (wb_adr_i == `LPPS_ADR_CCFG) begin
          ccfg_r <= ccfgMerge[12:0];
        end
      end
    end
  end

  // ==========================================================
  // Phase sequencer. Every interval reloads its own exact count, so one
  // interval's error never carries into the next.
  always @(posedge clk) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 32'h0;
      total_r <= 32'h0;
      burstIdx_r <= 3'h0;
      central_r <= 1'b0;
      rSnap_r <= 13'h0;
      cSnap_r <= 13'h0;
      scr_r <= 23'h0;
      poly_r <= 3'h0;
      div_r <= 16'h1;
      symCnt_r <= 16'h0;
      prevDiv_r <= 16'hFFFF;
      ownBurst_r <= 1'b0;
      orderErr_r <= 1'b0;
      limitErr_r <= 1'b0;
      hsStart <= 1'b0;
      probeBusy <= 1'b0;
      txActive <= 1'b0;
      txLevel <= 1'b0;
      txLevelCode <= `LPPS_LVL_NEG;
      symbolStrobe <= 1'b0;
      txBackoff <= 4'h0;
      txMaskSel <= 6'h0;
    end else begin
      hsStart <= 1'b0;
      symbolStrobe <= 1'b0;
      if (st_r != ST_IDLE) begin
        total_r <= total_r + 32'd1;
        cnt_r <= cnt_r - 32'd1;
      end
      // Symbols only while this unit owns a burst, silent otherwise
      if (ownBurst_r) begin
        if (symCnt_r == 16'h0) begin
          symCnt_r <= div_r - 16'd1;
          scr_r <= {scr_r[21:0], 1'b1 ^ tapBit(central_r, poly_r, scr_r)};
          txLevel <= 1'b1 ^ tapBit(central_r, poly_r, scr_r);
          txLevelCode <= (1'b1 ^ tapBit(central_r, poly_r, scr_r)) ? `LPPS_LVL_POS : `LPPS_LVL_NEG;
          symbolStrobe <= 1'b1;
        end else begin
          symCnt_r <= symCnt_r - 16'd1;
        end
      end
      case (st_r)
        ST_IDLE: begin
          // Start only when the optional probe was selected
          if (hsEnd && ctrl_r[`LPPS_CTRL_EN]) begin
            st_r <= ST_HP;
            cnt_r <= GAP_CYC - 32'd1;
            total_r <= 32'h0;
            burstIdx_r <= 3'h0;
            central_r <= ctrl_r[`LPPS_CTRL_CENTRAL];
            rSnap_r <= rcfg_r;
            cSnap_r <= ccfg_r;
            orderErr_r <= 1'b0;
            limitErr_r <= 1'b0;
            prevDiv_r <= 16'hFFFF;
            probeBusy <= 1'b1;
          end
        end
        ST_HP, ST_RGAP, ST_PRC, ST_CGAP: begin
          // Silent interval; table entry for the next burst is already read
          if (cnt_r == 32'h0) begin
            st_r <= centralSlots ? ST_CBURST : ST_RBURST;
            cnt_r <= durCycles(centralSlots ? cSnap_r[`LPPS_CFG_DUR_MSB:`LPPS_CFG_DUR_LSB] :
                               rSnap_r[`LPPS_CFG_DUR_MSB:`LPPS_CFG_DUR_LSB]) - 32'd1;
            ownBurst_r <= (centralSlots == central_r);
            txActive <= (centralSlots == central_r);
            scr_r <= 23'h0;
            symCnt_r <= 16'h0;
            poly_r <= entry[`LPPS_ENT_POLY_MSB:`LPPS_ENT_POLY_LSB];
            div_r <= (entry[`LPPS_ENT_DIV_MSB:0] == 16'h0) ? 16'h1 : entry[`LPPS_ENT_DIV_MSB:0];
            txMaskSel <= entry[`LPPS_ENT_MASK_MSB:`LPPS_ENT_MASK_LSB];
            txBackoff <= centralSlots ? cSnap_r[`LPPS_CFG_PBO_MSB:`LPPS_CFG_PBO_LSB] :
                         rSnap_r[`LPPS_CFG_PBO_MSB:`LPPS_CFG_PBO_LSB];
            // Larger divider means lower rate; a rise breaks ascending order
            if (burstIdx_r != 3'h0 && entry[`LPPS_ENT_DIV_MSB:0] > prevDiv_r) begin
              orderErr_r <= 1'b1;
            end
            prevDiv_r <= entry[`LPPS_ENT_DIV_MSB:0];
          end
        end
        ST_RBURST: begin
          // Remote bursts in table order; a rate drop only sets orderErr_r
          if (cnt_r == 32'h0) begin
            ownBurst_r <= 1'b0;
            txActive <= 1'b0;
            cnt_r <= GAP_CYC - 32'd1;
            if (burstIdx_r == rSnap_r[`LPPS_CFG_CNT_MSB:0]) begin
              st_r <= ST_PRC;
              burstIdx_r <= 3'h0;
              prevDiv_r <= 16'hFFFF;
            end else begin
              st_r <= ST_RGAP;
              burstIdx_r <= burstIdx_r + 3'd1;
            end
          end
        end
        ST_CBURST: begin
          // Central bursts follow the same pattern
          if (cnt_r == 32'h0) begin
            ownBurst_r <= 1'b0;
            txActive <= 1'b0;
            cnt_r <= GAP_CYC - 32'd1;
            if (burstIdx_r == cSnap_r[`LPPS_CFG_CNT_MSB:0]) begin
              st_r <= ST_PH;
            end else begin
              st_r <= ST_CGAP;
              burstIdx_r <= burstIdx_r + 3'd1;
            end
          end
        end
        default: begin
          // Final silence, then hand the line back to the handshake
          if (cnt_r == 32'h0) begin
            st_r <= ST_IDLE;
            hsStart <= 1'b1;
            probeBusy <= 1'b0;
          end
        end
      endcase
      // Hard stop: the phase never outlives its total budget
      if (st_r != ST_IDLE && total_r >= TOTAL_CYC - 32'd1) begin
        st_r <= ST_IDLE;
        ownBurst_r <= 1'b0;
        txActive <= 1'b0;
        symbolStrobe <= 1'b0; // No symbol may trail an aborted burst
        hsStart <= 1'b1;
        probeBusy <= 1'b0;
        limitErr_r <= 1'b1;
      end
    end
  end

endmodule

//--- hw/lpps_defines.vh
/*
  Constants for the line probe preactivation sequencer: register offsets,
  field positions, reset values and timing figures.
  Assumes a 100 MHz system clock and a byte-addressed Wishbone slave.
*/
`ifndef LPPS_DEFINES_VH
`define LPPS_DEFINES_VH

// ==========================================================
// Clock and timing figures
`define LPPS_CLK_KHZ 100000
`define LPPS_GAP_MS 200
`define LPPS_DUR_STEP_MS 50
`define LPPS_TOTAL_MS 10000
`define LPPS_GAP_CYC (`LPPS_GAP_MS * `LPPS_CLK_KHZ)
`define LPPS_DUR_STEP_CYC (`LPPS_DUR_STEP_MS * `LPPS_CLK_KHZ)
`define LPPS_TOTAL_CYC (`LPPS_TOTAL_MS * `LPPS_CLK_KHZ)

// ==========================================================
// Register byte offsets
`define LPPS_ADR_CTRL 8'h00
`define LPPS_ADR_RCFG 8'h04
`define LPPS_ADR_CCFG 8'h08
`define LPPS_ADR_STAT 8'h0C
`define LPPS_ADR_TAB_HI 2'b01

// ==========================================================
// Field positions
`define LPPS_CTRL_EN 0
`define LPPS_CTRL_CENTRAL 1
`define LPPS_CFG_CNT_MSB 2
`define LPPS_CFG_DUR_LSB 3
`define LPPS_CFG_DUR_MSB 8
`define LPPS_CFG_PBO_LSB 9
`define LPPS_CFG_PBO_MSB 12
`define LPPS_ENT_DIV_MSB 15
`define LPPS_ENT_POLY_LSB 16
`define LPPS_ENT_POLY_MSB 18
`define LPPS_ENT_MASK_LSB 19
`define LPPS_ENT_MASK_MSB 24
`define LPPS_ENT_W 25

// ==========================================================
// Reset values and line level codes
`define LPPS_CTRL_RST 2'h0
`define LPPS_CFG_RST 13'h0C02
`define LPPS_LVL_NEG 4'h3
`define LPPS_LVL_POS 4'h8

`endif

//--- hw/lpps_rate_mem.v
/*
  Small rate table: sixteen entries, eight per unit, each holding the
  symbol divider, scrambler index and mask setting of one probe burst.
  Assumes one writer and one reader on the same clock; read data registered.
*/
`timescale 1ns/1ps
`include "lpps_defines.vh"

module lpps_rate_mem (
  // Clock
  input wire clk,
  // Write port
  input wire wrEn,
  input wire [3:0] wrAddr,
  input wire [`LPPS_ENT_W-1:0] wrData,
  // Read port
  input wire [3:0] rdAddr,
  output reg [`LPPS_ENT_W-1:0] rdData
);

  // ==========================================================
  // Storage, no reset needed since software loads it before use
  reg [`LPPS_ENT_W-1:0] mem [0:15];

  // Write and registered read
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

//--- tb/lpps_seq_monitor.sv
/*
  Port checker for the probe sequencer: bus answer, burst framing, level map.
  Assumes binding to the sequencer top with its phase limit handed on.
*/
`timescale 1ns/1ps
module lpps_seq_monitor #(
  parameter [31:0] TOTAL_CYC = 32'd100000
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Phase and line
  input wire hsStart,
  input wire probeBusy,
  input wire txActive,
  input wire txLevel,
  input wire [3:0] txLevelCode,
  input wire symbolStrobe,
  input wire [3:0] txBackoff,
  input wire [5:0] txMaskSel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Phase length counter, cleared while idle
  reg [31:0] busyCnt_r;
  always @(posedge clk) begin
    busyCnt_r <= (!rst_n || !probeBusy) ? 32'h0 : busyCnt_r + 32'h1;
  end
  // ==========================================================
  // Assertions
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  strobe_burst_a: assert property (symbolStrobe |-> txActive || $past(txActive)) else $error("idle strobe");
  level_map_a: assert property (txLevelCode == (txLevel ? 4'h8 : 4'h3)) else $error("bad level code");
  first_bit_a: assert property ($rose(txActive) |=> symbolStrobe && txLevel) else $error("bad first bit");
  quiet_idle_a: assert property (!probeBusy |-> !txActive && !symbolStrobe) else $error("idle send");
  start_gap_a: assert property ($rose(probeBusy) |-> !txActive [*8]) else $error("short lead gap");
  tail_gap_a: assert property ($fell(txActive) |-> (!txActive && !hsStart) [*8]) else $error("short gap");
  cfg_steady_a: assert property (txActive && $past(txActive) |-> $stable(txBackoff) && $stable(txMaskSel))
    else $error("burst setting moved");
  phase_limit_a: assert property (busyCnt_r <= TOTAL_CYC) else $error("phase too long");
  hs_pulse_a: assert property (hsStart |=> !hsStart && !probeBusy) else $error("bad restart");
  // Main scenarios reached
  burst_c: cover property ($rose(txActive));
  restart_c: cover property (hsStart);
  bus_c: cover property (wb_ack_o);
endmodule

//--- tb/lpps_far_end.sv
/*
  Far-end model: starts the phase and watches the line bit by bit.
  Assumes entry k holds polynomial k, mask 5k and divider 6-k.
*/
`timescale 1ns/1ps
module lpps_far_end #(
  parameter integer GAP = 20,
  parameter integer DUR = 30
) (
  // Clock, reset, bench control
  input wire clk,
  input wire rst_n,
  input wire go,
  input wire central,
  input wire [3:0] pbo,
  // Sequencer side
  input wire txActive,
  input wire txLevel,
  input wire [3:0] txLevelCode,
  input wire symbolStrobe,
  input wire [3:0] txBackoff,
  input wire [5:0] txMaskSel,
  input wire hsStart,
  output reg hsEnd,
  // Measurements
  output integer err,
  output integer bursts,
  output integer firstGap,
  output integer lastGap
);
  reg [22:0] hist; // Bit k-1 holds s(n-k)
  reg actPrev;
  reg bitExp;
  integer cnt, sinceFall, len, sym;
  // Feedback taps of the selected polynomial
  function automatic logic taps(input logic c, input [2:0] i, input [22:0] h);
    case (i)
      3'd0: taps = c ? h[4] ^ h[22] : h[17] ^ h[22];
      3'd1: taps = h[0];
      3'd2: taps = c ? h[1] ^ h[4] : h[2] ^ h[4];
      3'd3: taps = c ? h[0] ^ h[5] : h[4] ^ h[5];
      3'd4: taps = c ? h[2] ^ h[6] : h[3] ^ h[6];
      default: taps = c ? h[1] ^ h[2] ^ h[3] ^ h[7] : h[3] ^ h[4] ^ h[5] ^ h[7];
    endcase
  endfunction
  // ==========================================================
  // Observer; gaps and burst lengths allow one cycle either way, symbol spacing must match exactly
  always @(posedge clk) begin
    hsEnd <= go;
    cnt = cnt + 1;
    sinceFall = sinceFall + 1;
    len = len + 1;
    sym = sym + 1;
    if (!rst_n) begin
      err = 0;
      bursts = 0;
      actPrev = 0;
    end else begin
      if (hsEnd) begin
        cnt = 0;
        bursts = 0;
      end
      // Symbols first: the closing strobe of a burst still belongs to it
      if (symbolStrobe) begin
        bitExp = 1'b1 ^ taps(central, bursts[2:0], hist);
        if (txLevel !== bitExp || txLevelCode !== (bitExp ? 4'h8 : 4'h3)) err = err + 1;
        if (sym != ((hist == 0) ? 1 : 6 - bursts)) err = err + 1;
        hist = {hist[21:0], bitExp};
        sym = 0;
      end
      if (txActive && !actPrev) begin
        if (bursts == 0) firstGap = cnt;
        else if (sinceFall < GAP - 1 || sinceFall > GAP + 1) err = err + 1;
        hist = 0;
        len = 0;
        sym = 0;
      end
      if (!txActive && actPrev) begin
        if (len < DUR - 1 || len > DUR + 1) err = err + 1;
        bursts = bursts + 1;
        sinceFall = 0;
      end
      if (hsStart) lastGap = sinceFall;
      if (txActive && actPrev && (txBackoff !== pbo || txMaskSel !== 6'(bursts * 5))) err = err + 1;
      actPrev = txActive;
    end
  end
endmodule

//--- tb/test_lpps_sequencer.sv
/*
  Bench for the probe sequencer: registers, disabled phase, both roles.
  Assumes shortened gap, step and limit parameters.
*/
`timescale 1ns/1ps
module test_lpps_sequencer;
  localparam integer GAP = 20;
  localparam integer DUR = 30; // Three steps of ten cycles
  localparam [31:0] CFG = 32'h0000121D; // Six bursts, three steps, 9 dB
  reg clk, rst_n, cyc, stb, we, go, central;
  reg [7:0] adr;
  reg [31:0] datI, rd;
  reg [3:0] sel;
  wire [31:0] datO;
  wire ack, hsEnd, hsStart, probeBusy, txActive, txLevel, symbolStrobe;
  wire [3:0] txLevelCode, txBackoff;
  wire [5:0] txMaskSel;
  integer fails, cmp_count, tick, err, bursts, firstGap, lastGap, k;
  lpps_sequencer #(.GAP_CYC(32'd20), .DUR_STEP_CYC(32'd10), .TOTAL_CYC(32'd100000)) i_lpps_sequencer (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(datI), .wb_sel_i(sel), .wb_dat_o(datO), .wb_ack_o(ack), .hsEnd(hsEnd), .hsStart(hsStart),
    .probeBusy(probeBusy), .txActive(txActive), .txLevel(txLevel), .txLevelCode(txLevelCode),
    .symbolStrobe(symbolStrobe), .txBackoff(txBackoff), .txMaskSel(txMaskSel));
  lpps_far_end #(.GAP(GAP), .DUR(DUR)) i_lpps_far_end (
    .clk(clk), .rst_n(rst_n), .go(go), .central(central), .pbo(4'h9), .txActive(txActive),
    .txLevel(txLevel), .txLevelCode(txLevelCode), .symbolStrobe(symbolStrobe), .txBackoff(txBackoff),
    .txMaskSel(txMaskSel), .hsStart(hsStart), .hsEnd(hsEnd), .err(err), .bursts(bursts),
    .firstGap(firstGap), .lastGap(lastGap));
  // ==========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tick = tick + 1;
    if (tick == 10000) begin
      fails = fails + 1;
      test_done;
    end
  end
  // ==========================================================
  // Shared tasks
  task check(input [31:0] exp, input [31:0] got, input [8*12-1:0] what);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value %0s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  // Timing within one cycle of nominal
  task near(input integer exp, input integer got, input [8*12-1:0] what);
    begin
      check(1, (got >= exp - 1 && got <= exp + 1), what);
    end
  endtask
  // One classic single cycle; read data kept in rd
  task wbCycle(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      sel <= s;
      // Only the hang guard ends this wait
      do begin
        @(posedge clk);
      end while (ack !== 1'b1);
      rd = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  // Start a phase and wait for the restart pulse
  task runPhase(input role);
    integer n;
    begin
      @(posedge clk);
      central <= role;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (hsStart !== 1'b1 && n < 3000);
      if (hsStart !== 1'b1) fails = fails + 1;
      repeat (2) @(posedge clk);
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, cyc, stb, we, go, central, adr, datI, sel} = 0;
    {fails, cmp_count, tick} = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wbCycle(0, 8'h04, 0, 4'hF);
    check(32'h0C02, rd, "rcfg reset");
    wbCycle(1, 8'h08, 32'h1D, 4'h1);
    wbCycle(0, 8'h08, 0, 4'hF);
    check(32'h0C1D, rd, "ccfg byte");
    wbCycle(1, 8'h04, CFG, 4'hF);
    wbCycle(1, 8'h08, CFG, 4'hF);
    wbCycle(0, 8'h04, 0, 4'hF);
    check(CFG, rd, "rcfg");
    for (k = 0; k < 6; k = k + 1) begin
      wbCycle(1, 8'h40 + 4 * k, (k * 5 << 19) | (k << 16) | (6 - k), 4'hF);
      wbCycle(1, 8'h60 + 4 * k, (k * 5 << 19) | (k << 16) | (6 - k), 4'hF);
    end
    wbCycle(0, 8'h44, 0, 4'hF);
    check(0, rd, "table read");
    wbCycle(0, 8'hFC, 0, 4'hF);
    check(0, rd, "unmapped");
    $display("test registers done");
    // Probe not selected: no phase at all
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    // Long enough for a wrongly started first burst to have ended
    repeat (60) @(posedge clk);
    check(0, probeBusy, "busy off");
    check(0, bursts, "bursts off");
    $display("test disabled done");
    wbCycle(1, 8'h00, 32'h1, 4'hF);
    runPhase(1'b0);
    check(6, bursts, "remote count");
    check(0, err, "remote line");
    near(GAP, firstGap, "lead gap");
    near(7 * GAP + 6 * DUR, lastGap, "remote tail");
    wbCycle(0, 8'h0C, 0, 4'hF);
    check(0, rd[7:6], "order flags");
    $display("test remote done");
    wbCycle(1, 8'h00, 32'h3, 4'hF);
    runPhase(1'b1);
    check(6, bursts, "central cnt");
    check(0, err, "central line");
    near(7 * GAP + 6 * DUR, firstGap, "central lead");
    near(GAP, lastGap, "final gap");
    $display("test central done");
    test_done;
  end
endmodule
bind lpps_sequencer lpps_seq_monitor #(.TOTAL_CYC(TOTAL_CYC)) i_lpps_seq_monitor (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .hsStart(hsStart), .probeBusy(probeBusy), .txActive(txActive), .txLevel(txLevel),
  .txLevelCode(txLevelCode), .symbolStrobe(symbolStrobe), .txBackoff(txBackoff), .txMaskSel(txMaskSel));
